// ==== sfs_pkg.sv ====
// Constants, types and decode functions shared by both ends of the frame link
// Operation
// - Variable mode: data length set by chip select
// - Variable mode: host sends mode bits 00
// - Variable write: flag 1, mode 00
// - Host lowers chip select before first bit
// - Host shifts out bits on falling clock
// - Host raises chip select after last bit
// - Write bytes land at consecutive offsets
// - Decode 00000 common, 00110 socket1 transmit
// - Decode 11101 socket7 registers, 01111 socket3 receive
// - Variable read: flag 0, mode 00
// - Device drives read data, host samples rising
// - Read bytes come from consecutive offsets
// - Fixed mode: chip select tied low, unshared
// - Fixed mode: length from mode bits only
// - Fixed frames share the variable frame layout
// - Fixed mode: only 1, 2, 4 bytes
// - Prefer variable mode over fixed mode
// - Mode 01/10/11 give 1/2/4 bytes
// - Bytes travel most significant bit first
package sfs_pkg;
    localparam int ADDR_W   = 16;
    localparam int BLK_W    = 5;
    localparam int OM_W     = 2;
    localparam int BYTE_W   = 8;
    localparam int HDR_BITS = ADDR_W + BLK_W + 1 + OM_W;
    localparam int ADDR_LSB = BLK_W + 1 + OM_W;
    localparam int BLK_LSB  = 1 + OM_W;
    localparam int RW_POS   = OM_W;
    localparam int WR_W     = BLK_W + ADDR_W + BYTE_W;
    localparam int FIFO_DEPTH = 8;

    localparam logic [OM_W-1:0] OM_VAR  = 2'h0;
    localparam logic [OM_W-1:0] OM_ONE  = 2'h1;
    localparam logic [OM_W-1:0] OM_TWO  = 2'h2;
    localparam logic [OM_W-1:0] OM_FOUR = 2'h3;
    localparam logic RW_READ  = 1'b0;
    localparam logic RW_WRITE = 1'b1;

    localparam logic [BLK_W-1:0] BLK_COMMON = 5'h00;
    localparam logic [1:0]       SUB_REG    = 2'h1;
    localparam logic [1:0]       SUB_TX     = 2'h2;
    localparam logic [1:0]       SUB_RX     = 2'h3;

    localparam logic [2:0] LEN_VAR  = 3'h0;
    localparam logic [2:0] LEN_ONE  = 3'h1;
    localparam logic [2:0] LEN_TWO  = 3'h2;
    localparam logic [2:0] LEN_FOUR = 3'h4;

    localparam int CORE_PERIOD_NS = 5;
    localparam int SCLK_HALF_NS   = 40;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

    typedef enum logic [2:0] {TGT_COMMON, TGT_SOCK_REG, TGT_SOCK_TX, TGT_SOCK_RX, TGT_RSVD} sfs_tgt_e;

    // Select value = socket * 4 + sub-block; code 0 is the common block
    function automatic sfs_tgt_e blk_kind(input logic [BLK_W-1:0] blk);
        sfs_tgt_e k;
        k = TGT_RSVD;
        if (blk == BLK_COMMON) begin
            k = TGT_COMMON;
        end else if (blk[1:0] == SUB_REG) begin
            k = TGT_SOCK_REG;
        end else if (blk[1:0] == SUB_TX) begin
            k = TGT_SOCK_TX;
        end else if (blk[1:0] == SUB_RX) begin
            k = TGT_SOCK_RX;
        end
        return k;
    endfunction : blk_kind

    // Zero means the data phase is bounded by chip select
    function automatic logic [2:0] fixed_len(input logic [OM_W-1:0] om);
        logic [2:0] n;
        unique case (om)
            OM_ONE:  n = LEN_ONE;
            OM_TWO:  n = LEN_TWO;
            OM_FOUR: n = LEN_FOUR;
            default: n = LEN_VAR;
        endcase
        return n;
    endfunction : fixed_len
endpackage : sfs_pkg

// ==== sfs_link_if.sv ====
// Serial frame link between the host end and the device end
`timescale 1ns/1ps
interface sfs_link_if;
    logic sclk;
    logic scs_n;
    logic mosi;
    logic miso;
    modport dev (input sclk, input scs_n, input mosi, output miso);
    modport host (output sclk, output scs_n, output mosi, input miso);
endinterface : sfs_link_if

// ==== sfs_dev.sv ====
// Device end of the frame link with its write FIFO
`timescale 1ns/1ps
module sfs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sfs_fifo

module sfs_dev (
    input  wire logic                         CORE_CLK,
    input  wire logic                         RST,
    input  wire logic                         CE,
    sfs_link_if.dev                           LINK,
    output logic                              WR_VALID,
    input  wire logic                         WR_READY,
    output logic      [sfs_pkg::ADDR_W-1:0]   WR_ADDR,
    output logic      [sfs_pkg::BLK_W-1:0]    WR_BLK,
    output sfs_pkg::sfs_tgt_e                 WR_KIND,
    output logic      [sfs_pkg::BYTE_W-1:0]   WR_DATA,
    output logic                              RD_REQ,
    output logic      [sfs_pkg::ADDR_W-1:0]   RD_ADDR,
    output logic      [sfs_pkg::BLK_W-1:0]    RD_BLK,
    output sfs_pkg::sfs_tgt_e                 RD_KIND,
    input  wire logic                         RD_ACK,
    input  wire logic [sfs_pkg::BYTE_W-1:0]   RD_DATA,
    output logic                              FRAME_ACTIVE,
    output logic                              OVERRUN
);
    typedef enum logic {S_HDR, S_DATA} sfs_dst_e;

    logic                            sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic                            cs_s1_r, cs_s2_r, cs_s3_r;
    logic                            mosi_s1_r, mosi_s2_r;
    logic                            rise, fall, cs_act, cs_start;
    sfs_dst_e                        st_r;
    logic [sfs_pkg::HDR_BITS-1:0]    hdr_r;
    logic [sfs_pkg::HDR_BITS-1:0]    hdr_nxt;
    logic [4:0]                      bit_r;
    logic [2:0]                      byte_r;
    logic [sfs_pkg::BLK_W-1:0]       blk_r;
    logic                            rw_r;
    logic [sfs_pkg::OM_W-1:0]        om_r;
    logic [sfs_pkg::ADDR_W-1:0]      addr_r;
    logic [sfs_pkg::BYTE_W-1:0]      rx_r;
    logic [sfs_pkg::BYTE_W-1:0]      rx_nxt;
    logic [sfs_pkg::BYTE_W-1:0]      tx_r;
    logic [sfs_pkg::BYTE_W-1:0]      pre_r;
    logic                            first_r, hold_r, load_r;
    logic                            hdr_done, byte_done, push, push_ok;
    logic [sfs_pkg::WR_W-1:0]        fifo_out;

    // Link pins cross into the core clock; stage two feeds logic, stage three only the edge detects
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_s3_r   <= 1'b1;
            mosi_s1_r <= 1'b0;
            mosi_s2_r <= 1'b0;
        end else if (CE) begin
            sclk_s1_r <= LINK.sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            cs_s1_r   <= LINK.scs_n;
            cs_s2_r   <= cs_s1_r;
            cs_s3_r   <= cs_s2_r;
            mosi_s1_r <= LINK.mosi;
            mosi_s2_r <= mosi_s1_r;
        end
    end

    assign cs_act    = !cs_s2_r;
    assign cs_start  = cs_s3_r && !cs_s2_r;
    assign rise      = CE && cs_act && sclk_s2_r && !sclk_s3_r;
    assign fall      = CE && cs_act && !sclk_s2_r && sclk_s3_r;
    assign hdr_nxt   = {hdr_r[sfs_pkg::HDR_BITS-2:0], mosi_s2_r};
    assign rx_nxt    = {rx_r[sfs_pkg::BYTE_W-2:0], mosi_s2_r};
    assign hdr_done  = rise && (st_r == S_HDR) && (bit_r == 5'(sfs_pkg::HDR_BITS - 1));
    assign byte_done = rise && (st_r == S_DATA) && (bit_r == 5'(sfs_pkg::BYTE_W - 1));
    assign push      = byte_done && (rw_r == sfs_pkg::RW_WRITE);

    // Frame sequencing; chip select high aborts in either mode
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_r   <= S_HDR;
            bit_r  <= '0;
            byte_r <= '0;
            hdr_r  <= '0;
            rx_r   <= '0;
        end else if (CE) begin
            if (!cs_act) begin
                st_r  <= S_HDR;
                bit_r <= '0;
            end else if (rise) begin
                if (st_r == S_HDR) begin
                    hdr_r  <= hdr_nxt;
                    bit_r  <= hdr_done ? '0 : bit_r + 1'b1;
                    byte_r <= '0;
                    if (hdr_done) begin
                        st_r <= S_DATA;
                    end
                end else begin
                    rx_r  <= rx_nxt;
                    bit_r <= byte_done ? '0 : bit_r + 1'b1;
                    if (byte_done) begin
                        byte_r <= byte_r + 1'b1;
                        // Fixed length ends without chip select; variable length runs on
                        // The byte count wraps at eight, so variable frames must never match
                        if (sfs_pkg::fixed_len(om_r) != sfs_pkg::LEN_VAR &&
                            sfs_pkg::fixed_len(om_r) == byte_r + 1'b1) begin
                            st_r <= S_HDR;
                        end
                    end
                end
            end
        end
    end

    // Header fields and the running offset
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            blk_r  <= '0;
            rw_r   <= sfs_pkg::RW_READ;
            om_r   <= sfs_pkg::OM_VAR;
            addr_r <= '0;
        end else if (CE) begin
            if (hdr_done) begin
                addr_r <= hdr_nxt[sfs_pkg::HDR_BITS-1:sfs_pkg::ADDR_LSB];
                blk_r  <= hdr_nxt[sfs_pkg::ADDR_LSB-1:sfs_pkg::BLK_LSB];
                rw_r   <= hdr_nxt[sfs_pkg::RW_POS];
                om_r   <= hdr_nxt[sfs_pkg::OM_W-1:0];
            end else if (push || RD_REQ) begin
                addr_r <= addr_r + 1'b1;
            end
        end
    end

    // Read path: fetch a byte ahead so each falling edge has its data ready
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RD_REQ  <= 1'b0;
            RD_ADDR <= '0;
            RD_BLK  <= '0;
            first_r <= 1'b0;
            hold_r  <= 1'b0;
            load_r  <= 1'b0;
            tx_r    <= '0;
            pre_r   <= '0;
        end else if (CE) begin
            RD_REQ <= 1'b0;
            if (hdr_done) begin
                first_r <= (hdr_nxt[sfs_pkg::RW_POS] == sfs_pkg::RW_READ);
                RD_REQ  <= (hdr_nxt[sfs_pkg::RW_POS] == sfs_pkg::RW_READ);
                RD_ADDR <= hdr_nxt[sfs_pkg::HDR_BITS-1:sfs_pkg::ADDR_LSB];
                RD_BLK  <= hdr_nxt[sfs_pkg::ADDR_LSB-1:sfs_pkg::BLK_LSB];
                hold_r  <= 1'b1;
                load_r  <= 1'b0;
            end else if (RD_ACK && first_r) begin
                tx_r    <= RD_DATA;
                first_r <= 1'b0;
                RD_REQ  <= 1'b1;
                RD_ADDR <= addr_r;
            end else if (RD_ACK) begin
                pre_r <= RD_DATA;
            end
            if (byte_done) begin
                load_r <= 1'b1;
            end
            if (!cs_act) begin
                first_r <= 1'b0;
                hold_r  <= 1'b0;
                load_r  <= 1'b0;
            end else if (fall && st_r == S_DATA && rw_r == sfs_pkg::RW_READ) begin
                if (hold_r) begin
                    hold_r <= 1'b0;
                end else if (load_r) begin
                    tx_r    <= pre_r;
                    load_r  <= 1'b0;
                    RD_REQ  <= 1'b1;
                    RD_ADDR <= addr_r;
                end else begin
                    tx_r <= {tx_r[sfs_pkg::BYTE_W-2:0], 1'b0};
                end
            end
        end
    end

    assign LINK.miso = tx_r[sfs_pkg::BYTE_W-1] && cs_act && (rw_r == sfs_pkg::RW_READ);
    assign RD_KIND   = sfs_pkg::blk_kind(RD_BLK);
    assign FRAME_ACTIVE = cs_act;

    // The link cannot be stalled, so a full FIFO drops the byte and flags it
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            OVERRUN <= 1'b0;
        end else if (CE) begin
            if (push && !push_ok) begin
                OVERRUN <= 1'b1;
            end else if (cs_start) begin
                OVERRUN <= 1'b0;
            end
        end
    end

    sfs_fifo #(
        .WIDTH (sfs_pkg::WR_W),
        .DEPTH (sfs_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (CORE_CLK),
        .rst       (RST),
        .ce        (CE),
        .in_valid  (push),
        .in_ready  (push_ok),
        .in_data   ({blk_r, addr_r, rx_nxt}),
        .out_valid (WR_VALID),
        .out_ready (WR_READY),
        .out_data  (fifo_out)
    );

    assign WR_BLK  = fifo_out[sfs_pkg::WR_W-1:sfs_pkg::ADDR_W+sfs_pkg::BYTE_W];
    assign WR_ADDR = fifo_out[sfs_pkg::ADDR_W+sfs_pkg::BYTE_W-1:sfs_pkg::BYTE_W];
    assign WR_DATA = fifo_out[sfs_pkg::BYTE_W-1:0];
    assign WR_KIND = sfs_pkg::blk_kind(WR_BLK);
endmodule : sfs_dev

// ==== sfs_host.sv ====
// Host end of the frame link: makes the serial clock and runs whole frames
`timescale 1ns/1ps
module sfs_host (
    input  wire logic                         CORE_CLK,
    input  wire logic                         RST,
    input  wire logic                         CE,
    sfs_link_if.host                          LINK,
    input  wire logic                         FIXED_TIE,
    input  wire logic                         CMD_VALID,
    output logic                              CMD_READY,
    input  wire logic [sfs_pkg::ADDR_W-1:0]   CMD_ADDR,
    input  wire logic [sfs_pkg::BLK_W-1:0]    CMD_BLK,
    input  wire logic                         CMD_WRITE,
    input  wire logic [sfs_pkg::OM_W-1:0]     CMD_MODE,
    input  wire logic [7:0]                   CMD_LEN,
    input  wire logic                         TX_VALID,
    output logic                              TX_READY,
    input  wire logic [sfs_pkg::BYTE_W-1:0]   TX_DATA,
    output logic                              RX_VALID,
    output logic      [sfs_pkg::BYTE_W-1:0]   RX_DATA,
    output logic                              BUSY
);
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LO, H_HI, H_FETCH, H_TAIL, H_GAP} sfs_hst_e;

    sfs_hst_e                        st_r;
    logic [3:0]                      tmr_r;
    logic                            tmo;
    logic                            miso_s1_r, miso_s2_r;
    logic [sfs_pkg::HDR_BITS-1:0]    out_r;
    logic [sfs_pkg::BYTE_W-1:0]      in_r;
    logic [4:0]                      bit_r;
    logic                            in_hdr_r;
    logic                            wr_r;
    logic [7:0]                      left_r;
    logic                            unit_end;
    logic                            sclk_r, cs_n_r;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else if (CE) begin
            miso_s1_r <= LINK.miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    assign tmo       = (tmr_r == 4'(sfs_pkg::SCLK_HALF_CYC - 1));
    assign unit_end  = in_hdr_r ? (bit_r == 5'(sfs_pkg::HDR_BITS - 1)) : (bit_r == 5'(sfs_pkg::BYTE_W - 1));
    assign CMD_READY = (st_r == H_IDLE);
    assign TX_READY  = (st_r == H_FETCH);
    assign BUSY      = (st_r != H_IDLE);

    // Clock divider: every half period ends on tmo
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            tmr_r <= '0;
        end else if (CE) begin
            tmr_r <= (tmo || st_r == H_IDLE || st_r == H_FETCH) ? '0 : tmr_r + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_r     <= H_IDLE;
            sclk_r   <= 1'b0;
            cs_n_r   <= 1'b1;
            out_r    <= '0;
            in_r     <= '0;
            bit_r    <= '0;
            in_hdr_r <= 1'b0;
            wr_r     <= 1'b0;
            left_r   <= '0;
            RX_VALID <= 1'b0;
            RX_DATA  <= '0;
        end else if (CE) begin
            RX_VALID <= 1'b0;
            unique case (st_r)
                H_IDLE: begin
                    if (CMD_VALID) begin
                        // Variable frames carry mode 00 and length from the command
                        out_r    <= {CMD_ADDR, CMD_BLK, CMD_WRITE, CMD_MODE};
                        wr_r     <= CMD_WRITE;
                        left_r   <= (CMD_MODE == sfs_pkg::OM_VAR) ?
                                    ((CMD_LEN == 8'h00) ? 8'h01 : CMD_LEN) :
                                    8'(sfs_pkg::fixed_len(CMD_MODE));
                        bit_r    <= '0;
                        in_hdr_r <= 1'b1;
                        cs_n_r   <= 1'b0;
                        st_r     <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (tmo) begin
                        st_r <= H_LO;
                    end
                end
                H_LO: begin
                    if (tmo) begin
                        sclk_r <= 1'b1;
                        in_r   <= {in_r[sfs_pkg::BYTE_W-2:0], miso_s2_r};
                        st_r   <= H_HI;
                    end
                end
                H_HI: begin
                    if (tmo) begin
                        sclk_r <= 1'b0;
                        if (!unit_end) begin
                            out_r <= {out_r[sfs_pkg::HDR_BITS-2:0], 1'b0};
                            bit_r <= bit_r + 1'b1;
                            st_r  <= H_LO;
                        end else begin
                            bit_r    <= '0;
                            in_hdr_r <= 1'b0;
                            if (!in_hdr_r) begin
                                left_r   <= left_r - 1'b1;
                                RX_VALID <= !wr_r;
                                RX_DATA  <= in_r;
                            end
                            if (!in_hdr_r && left_r == 8'h01) begin
                                st_r <= H_TAIL;
                            end else if (wr_r) begin
                                st_r <= H_FETCH;
                            end else begin
                                out_r <= '0;
                                st_r  <= H_LO;
                            end
                        end
                    end
                end
                H_FETCH: begin
                    // Clock stays low while the write source has nothing to give
                    if (TX_VALID) begin
                        out_r <= {TX_DATA, 16'h0000};
                        st_r  <= H_LO;
                    end
                end
                H_TAIL: begin
                    if (tmo) begin
                        cs_n_r <= 1'b1;
                        st_r   <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (tmo) begin
                        st_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign LINK.sclk  = sclk_r;
    assign LINK.scs_n = cs_n_r && !FIXED_TIE;
    assign LINK.mosi  = out_r[sfs_pkg::HDR_BITS-1];
endmodule : sfs_host

// ==== sfs_link_props.sv ====
// Wire-level checks on the serial frame link between the two ends
`timescale 1ns/1ps
module sfs_link_props (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic sclk,
    input wire logic scs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [7:0] rises_r;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Rises per frame; fixed-mode runs stay under 256 rises
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            rises_r <= 8'h00;
        else if (scs_n)
            rises_r <= 8'h00;
        else if ($rose(sclk))
            rises_r <= rises_r + 8'h01;
    end
    idle_clock_a: assert property (scs_n |-> !sclk) else $error("sclk moved outside a frame");
    // The device sees chip select through its synchroniser, so miso may linger two cycles
    miso_idle_a: assert property (scs_n && $past(scs_n, 2) |-> !miso) else $error("miso driven outside a frame");
    cs_lead_a: assert property ($fell(scs_n) |-> !sclk [*8]) else $error("sclk rose too soon");
    half_period_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk) else $error("sclk high time");
    mosi_hold_a: assert property (sclk |-> $stable(mosi)) else $error("mosi moved while sclk high");
    miso_setup_a: assert property ($rose(sclk) && !scs_n |-> $stable(miso)) else $error("miso moved at rise");
    cs_tail_a: assert property ($rose(scs_n) |-> !$past(sclk) && !$past(sclk, 8)) else $error("early release");
    frame_len_a: assert property ($rose(scs_n) |-> rises_r >= 8'h20 && rises_r[2:0] == 3'h0)
        else $error("frame not header plus whole bytes");
endmodule : sfs_link_props

// ==== spi_frame_slave_vdm_fdm_tb.sv ====
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module spi_frame_slave_vdm_fdm_tb;
    logic        clk = 1'b0, rst = 1'b1, fixed = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
    logic        tx_valid = 1'b0, wr_ready = 1'b1, rd_ack = 1'b0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [4:0]  cmd_blk = 5'h00;
    logic [1:0]  cmd_mode = 2'h0;
    logic [7:0]  cmd_len = 8'h00, tx_data = 8'h00, rd_data = 8'h00;
    logic [2:0]  rk = 3'h0;
    wire         cmd_ready, tx_ready, rx_valid, busy, wr_valid, rd_req, overrun, frame_active;
    wire  [7:0]  rx_data, wr_data;
    wire  [15:0] wr_addr, rd_addr;
    wire  [4:0]  wr_blk, rd_blk;
    sfs_pkg::sfs_tgt_e wr_kind, rd_kind;
    logic [7:0]  tx_q[$], rx_q[$];
    logic [31:0] wr_q[$];
    int          n_fail = 0, checks_done = 0, cyc = 0;
    sfs_link_if lk ();
    sfs_host i_sfs_host (.CORE_CLK(clk), .RST(rst), .CE(1'b1), .LINK(lk.host), .FIXED_TIE(fixed),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_ADDR(cmd_addr), .CMD_BLK(cmd_blk),
        .CMD_WRITE(cmd_write), .CMD_MODE(cmd_mode), .CMD_LEN(cmd_len), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .TX_DATA(tx_data), .RX_VALID(rx_valid), .RX_DATA(rx_data), .BUSY(busy));
    sfs_dev i_sfs_dev (.CORE_CLK(clk), .RST(rst), .CE(1'b1), .LINK(lk.dev), .WR_VALID(wr_valid),
        .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_BLK(wr_blk), .WR_KIND(wr_kind), .WR_DATA(wr_data),
        .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_BLK(rd_blk), .RD_KIND(rd_kind), .RD_ACK(rd_ack),
        .RD_DATA(rd_data), .FRAME_ACTIVE(frame_active), .OVERRUN(overrun));
    sfs_link_props i_sfs_link_props (.CORE_CLK(clk), .RST(rst), .sclk(lk.sclk), .scs_n(lk.scs_n),
        .mosi(lk.mosi), .miso(lk.miso));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    // Queues expected traffic, then runs one frame and waits for the host to go idle
    task automatic frame(input logic [15:0] a, input logic [4:0] b, input logic w, input logic [1:0] m,
                         input int n, input int keep, input sfs_pkg::sfs_tgt_e k);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = a[7:0] + i[7:0];
            if (w)
                tx_q.push_back(d ^ 8'hC3);
            else
                rx_q.push_back(d ^ 8'h5A);
            if (w && i < keep)
                wr_q.push_back({b, k, a + i[15:0], d ^ 8'hC3});
        end
        @(posedge clk);
        rk <= k;
        cmd_valid <= 1'b1;
        cmd_addr <= a;
        cmd_blk <= b;
        cmd_write <= w;
        cmd_mode <= m;
        cmd_len <= n[7:0];
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (20) @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
        repeat (30) @(posedge clk);
    endtask : frame
    initial forever #2.5 clk = ~clk;
    // Write feed, read data source and sinks; the source answers one cycle after each request
    always @(posedge clk) begin
        cyc++;
        if (tx_valid && tx_ready)
            void'(tx_q.pop_front());
        tx_valid <= tx_q.size() != 0;
        tx_data <= (tx_q.size() != 0) ? tx_q[0] : 8'h00;
        rd_ack <= rd_req;
        rd_data <= rd_addr[7:0] ^ 8'h5A;
        if (rd_req) check("rd_kind", rd_kind, rk);
        if (rx_valid) check("rx_data", rx_data, rx_q.pop_front());
        if (wr_valid && wr_ready) check("wr_word", {wr_blk, wr_kind, wr_addr, wr_data}, wr_q.pop_front());
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        frame(16'h0018, 5'h00, 1'b1, 2'h0, 1, 8, sfs_pkg::TGT_COMMON);
        frame(16'h0040, 5'h06, 1'b1, 2'h0, 5, 8, sfs_pkg::TGT_SOCK_TX);
        frame(16'h0003, 5'h1D, 1'b0, 2'h0, 1, 8, sfs_pkg::TGT_SOCK_REG);
        frame(16'h0100, 5'h0F, 1'b0, 2'h0, 5, 8, sfs_pkg::TGT_SOCK_RX);
        // Sink stalls: the FIFO keeps eight words and drops the rest
        wr_ready <= 1'b0;
        frame(16'h0200, 5'h0A, 1'b1, 2'h0, 10, 8, sfs_pkg::TGT_SOCK_TX);
        check("overrun", overrun, 32'h1);
        wr_ready <= 1'b1;
        fixed <= 1'b1;
        for (int m = 1; m < 4; m++) frame(16'h0300, 5'h01, 1'b1, m[1:0], (m == 3) ? 4 : m, 8, sfs_pkg::TGT_SOCK_REG);
        frame(16'h0400, 5'h0F, 1'b0, 2'h3, 4, 8, sfs_pkg::TGT_SOCK_RX);
        check("frame_act", frame_active, 32'h1);
        check("overrun_clr", overrun, 32'h0);
        fixed <= 1'b0;
        repeat (40) @(posedge clk);
        check("frame_idle", frame_active, 32'h0);
        check("wr_left", wr_q.size(), 32'h0);
        check("rx_left", rx_q.size(), 32'h0);
        test_done();
    end
endmodule : spi_frame_slave_vdm_fdm_tb
